//--- core/snkaux_out.sv
/*
  Output stage of the receiver auxiliary path: framed packet stream, packet
  memory mirror, status bundles, clock regeneration values, audio samples,
  oversample flag and two-wire pin conditioning.
  Assumes the decoder runs on clk_sys (the auxiliary clock) and hands over
  one word per cycle with first/last/crc markers already resolved.
*/
//
// Overview of operation
// - 72-bit aux words with valid qualifier
// - start marker on first valid word
// - end marker on last valid word
// - error flag on CRC-failed word
// - latest control packet on 6-bit output
// - video InfoFrame 123 or 112 bits wide
// - vendor InfoFrame as 61-bit bundle
// - mirror each word into packet buffer
// - 20-bit time stamp and divisor outputs
// - 256-bit audio bus with valid strobe
// - 5-bit format, bit4 marks 3D first-eight
// - all outputs but twiSdaOut (tied low) clocked by auxiliary clock
// - two-wire clock in, data bidirectional
// - RAM ports only with slave, no RAM
`timescale 1ns/1ps
`default_nettype none
module snkaux_out #(
  parameter bit INCL_FRL = 1'b0,
  parameter bit INCL_TWI = 1'b1,
  parameter bit INCL_ID_RAM = 1'b0,
  parameter int AVI_W = INCL_FRL ? snkaux_pkg::AVI_W_FRL : snkaux_pkg::AVI_W_TMDS
) (
  // clock and reset (the auxiliary clock)
  input wire logic clk_sys,
  input wire logic rst,
  // decoded words from the packet decoder
  input wire snkaux_pkg::snkaux_word_s inWord,
  // decoded status updates
  input wire logic gcpLoad,
  input wire logic [snkaux_pkg::GCP_W-1:0] gcpIn,
  input wire logic aviLoad,
  input wire logic [snkaux_pkg::AVI_W_FRL-1:0] aviIn,
  input wire logic vsiLoad,
  input wire logic [snkaux_pkg::VSI_W-1:0] vsiIn,
  input wire logic acrLoad,
  input wire logic [snkaux_pkg::ACR_W-1:0] ctsIn,
  input wire logic [snkaux_pkg::ACR_W-1:0] nIn,
  // decoded audio samples
  input wire logic audIn,
  input wire logic audFirst3d,
  input wire logic [3:0] audTypeIn,
  input wire logic [snkaux_pkg::AUD_W-1:0] audDataIn,
  // phy and connector pins
  input wire logic oversample_indicator,
  input wire logic twiSclIn,
  input wire logic twiSdaIn,
  // two-wire slave engine side
  input wire logic twiSdaPullLow,
  input wire logic [snkaux_pkg::ID_ADDR_W-1:0] twiRamAddr,
  input wire logic [snkaux_pkg::ID_WORD_W-1:0] display_id_ram_read_word,
  // auxiliary stream
  output logic auxValid,
  output logic [snkaux_pkg::AUX_W-1:0] auxData,
  output logic auxSop,
  output logic auxEop,
  output logic auxError,
  // packet memory
  output logic pktWr,
  output logic [snkaux_pkg::PKT_ADDR_W-1:0] pktAddr,
  output logic [snkaux_pkg::AUX_W-1:0] pktData,
  // status bundles
  output logic [snkaux_pkg::GCP_W-1:0] gcpStatus,
  output logic [AVI_W-1:0] aviStatus,
  output logic [snkaux_pkg::VSI_W-1:0] vsiStatus,
  output logic [snkaux_pkg::ACR_W-1:0] audioCts,
  output logic [snkaux_pkg::ACR_W-1:0] audioN,
  // audio
  output logic audio_sample_valid,
  output logic [snkaux_pkg::AUD_W-1:0] audioData,
  output logic [snkaux_pkg::AUD_FMT_W-1:0] audioFormat,
  // phy and two-wire side
  output logic oversampleSeen,
  output logic twiSclLevel,
  output logic twiSdaLevel,
  output logic twiSdaOut,
  output logic twiSdaOe,
  output logic [snkaux_pkg::ID_ADDR_W-1:0] displayIdRamAddr,
  output logic [snkaux_pkg::ID_WORD_W-1:0] displayIdWord
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  snkaux_pkg::snkaux_state_s r;
  snkaux_pkg::snkaux_state_s nxt;
  logic extRam;

  // ram ports live only when the slave exists without its own ram
  assign extRam = INCL_TWI && !INCL_ID_RAM;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // one pass builds every output but twiSdaOut; all land on the aux clock edge
  always_comb begin
    nxt = r;
    nxt.aux.valid = inWord.valid;
    nxt.aux.data = inWord.data;
    // markers gated by valid so idle cycles never carry a stale flag
    nxt.aux.sop = inWord.valid && inWord.first;
    nxt.aux.eop = inWord.valid && inWord.last;
    nxt.aux.err = inWord.valid && inWord.crcBad;
    // packet mirror: first word restarts at zero, counter wraps at depth
    nxt.pkt.wr = inWord.valid;
    nxt.pkt.data = inWord.data;
    nxt.pkt.addr = inWord.first ? snkaux_pkg::PKT_ADDR_RST : r.nextAddr;
    if (inWord.valid) begin
      nxt.nextAddr = nxt.pkt.addr + 7'h01;
      nxt.st = inWord.last ? snkaux_pkg::SA_IDLE : snkaux_pkg::SA_IN_PKT;
    end
    if (gcpLoad) begin
      nxt.gcp = gcpIn;
    end
    if (aviLoad) begin
      nxt.avi = aviIn;
    end
    if (vsiLoad) begin
      nxt.vsi = vsiIn;
    end
    // both values move together so a reader never sees a mixed pair
    if (acrLoad) begin
      nxt.cts = ctsIn;
      nxt.n = nIn;
    end
    nxt.aud.valid = audIn;
    if (audIn) begin
      nxt.aud.data = audDataIn;
      nxt.aud.fmt = {audFirst3d, audTypeIn};
    end
    // pin levels pass two flops before anything reads them
    nxt.overSampleSync = {r.overSampleSync[0], oversample_indicator};
    nxt.sclSync = {r.sclSync[0], twiSclIn & INCL_TWI};
    nxt.sdaSync = {r.sdaSync[0], twiSdaIn | ~INCL_TWI};
    nxt.sdaOe = INCL_TWI && twiSdaPullLow;
    nxt.idAddr = extRam ? twiRamAddr : '0;
    nxt.idWord = extRam ? display_id_ram_read_word : '0;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // synchronous reset; bundles clear so downstream sees defined zeros
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= '0;
      r.st <= snkaux_pkg::SA_IDLE;
      r.nextAddr <= snkaux_pkg::PKT_ADDR_RST;
      r.overSampleSync <= '0;
      r.sclSync <= snkaux_pkg::SYNC_RST;
      r.sdaSync <= snkaux_pkg::SYNC_RST;
    end else begin
      r <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state flops except twiSdaOut, a constant
  // ----------------------------------------------------------------
  assign auxValid = r.aux.valid;
  assign auxData = r.aux.data;
  assign auxSop = r.aux.sop;
  assign auxEop = r.aux.eop;
  assign auxError = r.aux.err;
  assign pktWr = r.pkt.wr;
  assign pktAddr = r.pkt.addr;
  assign pktData = r.pkt.data;
  assign gcpStatus = r.gcp;
  assign aviStatus = r.avi[AVI_W-1:0];
  assign vsiStatus = r.vsi;
  assign audioCts = r.cts;
  assign audioN = r.n;
  assign audio_sample_valid = r.aud.valid;
  assign audioData = r.aud.data;
  assign audioFormat = r.aud.fmt;
  assign oversampleSeen = r.overSampleSync[1];
  assign twiSclLevel = r.sclSync[1];
  assign twiSdaLevel = r.sdaSync[1];
  assign twiSdaOut = 1'b0; // open drain: only ever pulls low
  assign twiSdaOe = r.sdaOe;
  assign displayIdRamAddr = r.idAddr;
  assign displayIdWord = r.idWord;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_valid_follows: assert property (@(posedge clk_sys) disable iff (rst)
    inWord.valid |=> auxValid && auxData == $past(inWord.data))
    else $error("aux word not presented one cycle after input");
  chk_sop_first: assert property (@(posedge clk_sys) disable iff (rst)
    inWord.valid && inWord.first |=> auxSop)
    else $error("start marker missing on first word");
  chk_eop_last: assert property (@(posedge clk_sys) disable iff (rst)
    inWord.valid && inWord.last |=> auxEop)
    else $error("end marker missing on last word");
  chk_err_crc: assert property (@(posedge clk_sys) disable iff (rst)
    auxError |-> auxValid && $past(inWord.crcBad))
    else $error("error flag without crc failure");
  chk_markers_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !auxValid |-> !auxSop && !auxEop && !auxError)
    else $error("marker raised while qualifier low");
  chk_gcp_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !gcpLoad |=> $stable(gcpStatus))
    else $error("control status changed without update");
  chk_pkt_addr: assert property (@(posedge clk_sys) disable iff (rst)
    pktWr && !auxSop ##1 pktWr && !auxSop |-> pktAddr == $past(pktAddr) + 7'h01)
    else $error("buffer address did not advance by one");
  chk_pkt_start: assert property (@(posedge clk_sys) disable iff (rst)
    auxSop |-> pktWr && pktAddr == snkaux_pkg::PKT_ADDR_RST && pktData == auxData)
    else $error("packet buffer write misaligned with start");
  chk_acr_pair: assert property (@(posedge clk_sys) disable iff (rst)
    acrLoad |=> audioCts == $past(ctsIn) && audioN == $past(nIn))
    else $error("time stamp and divisor not loaded together");
  chk_audio_fmt: assert property (@(posedge clk_sys) disable iff (rst)
    audIn |=> audio_sample_valid && audioFormat[snkaux_pkg::AUD_FMT_3D_BIT] == $past(audFirst3d))
    else $error("3D first-eight flag wrong");
  chk_oversample_sync: assert property (@(posedge clk_sys) disable iff (rst)
    oversample_indicator [*3] |-> oversampleSeen)
    else $error("oversample flag not seen after two stages");
  chk_sda_drive: assert property (@(posedge clk_sys) disable iff (rst)
    twiSdaOe |-> INCL_TWI && $past(twiSdaPullLow))
    else $error("data pin driven without request");
endmodule
`default_nettype wire

//--- core/snkaux_pkg.sv
/*
  Shared constants and carriers for the receiver auxiliary/audio output block.
  Assumes one clock (the auxiliary clock) drives both the decoder and this block.
*/
`default_nettype none
package snkaux_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int AUX_W = 72;
  localparam int PKT_ADDR_W = 7;
  localparam int GCP_W = 6;
  localparam int AVI_W_FRL = 123;
  localparam int AVI_W_TMDS = 112;
  localparam int VSI_W = 61;
  localparam int ACR_W = 20;
  localparam int AUD_W = 256;
  localparam int AUD_FMT_W = 5;
  localparam int AUD_FMT_3D_BIT = 4;
  localparam int ID_ADDR_W = 32;
  localparam int ID_WORD_W = 8;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PKT_ADDR_W-1:0] PKT_ADDR_RST = 7'h00;
  localparam logic [1:0] SYNC_RST = 2'h3;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SA_IDLE = 2'b01,
    SA_IN_PKT = 2'b10
  } snkaux_pkt_e;
  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic crcBad;
    logic [AUX_W-1:0] data;
  } snkaux_word_s;
  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic err;
    logic [AUX_W-1:0] data;
  } snkaux_aux_s;
  typedef struct packed {
    logic wr;
    logic [PKT_ADDR_W-1:0] addr;
    logic [AUX_W-1:0] data;
  } snkaux_pkt_s;
  typedef struct packed {
    logic valid;
    logic [AUD_FMT_W-1:0] fmt;
    logic [AUD_W-1:0] data;
  } snkaux_aud_s;
  typedef struct packed {
    snkaux_pkt_e st;
    logic [PKT_ADDR_W-1:0] nextAddr;
    snkaux_aux_s aux;
    snkaux_pkt_s pkt;
    logic [GCP_W-1:0] gcp;
    logic [AVI_W_FRL-1:0] avi;
    logic [VSI_W-1:0] vsi;
    logic [ACR_W-1:0] cts;
    logic [ACR_W-1:0] n;
    snkaux_aud_s aud;
    logic [1:0] overSampleSync;
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic sdaOe;
    logic [ID_ADDR_W-1:0] idAddr;
    logic [ID_WORD_W-1:0] idWord;
  } snkaux_state_s;
endpackage
`default_nettype wire

//--- tb/snkaux_user_model.sv
/*
  Downstream user logic model: packet buffer that stores every strobed word,
  and the external display id ram that answers the slave address.
  Assumes the auxiliary clock drives both sides; the ram answers at once.
*/
`timescale 1ns/1ps
`default_nettype none
module snkaux_user_model (
  // clock
  input wire logic clk_sys,
  // packet buffer write side
  input wire logic pktWr,
  input wire logic [snkaux_pkg::PKT_ADDR_W-1:0] pktAddr,
  input wire logic [snkaux_pkg::AUX_W-1:0] pktData,
  // display id ram read side
  input wire logic [snkaux_pkg::ID_ADDR_W-1:0] displayIdRamAddr,
  output logic [snkaux_pkg::ID_WORD_W-1:0] display_id_ram_read_word
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [snkaux_pkg::AUX_W-1:0] mem [0:127];
  // one word per strobe, address and data taken in the strobe cycle
  always_ff @(posedge clk_sys) begin
    if (pktWr) begin
      mem[pktAddr] <= pktData;
    end
  end
  // ram content is a fixed scramble of the address, so stale reads show
  assign display_id_ram_read_word = displayIdRamAddr[7:0] ^ 8'h5A;
endmodule
`default_nettype wire

//--- tb/tb_sink_aux_audio_port_outputs.sv
/*
  Self-checking bench for the auxiliary/audio output stage.
  Assumes default build options: no fixed-rate link, two-wire slave on,
  no internal display id ram; all latencies are one cycle, pins two.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_sink_aux_audio_port_outputs;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0, rst = 1'b1;
  snkaux_pkg::snkaux_word_s inWord = '0;
  logic gcpLoad = 1'b0, aviLoad = 1'b0, vsiLoad = 1'b0, acrLoad = 1'b0, audIn = 1'b0, audFirst3d = 1'b0;
  logic [5:0] gcpIn = '0;
  logic [122:0] aviIn = '0;
  logic [60:0] vsiIn = '0;
  logic [19:0] ctsIn = '0, nIn = '0;
  logic [3:0] audTypeIn = '0;
  logic [255:0] audDataIn = '0;
  logic oversample_indicator = 1'b0, twiSclIn = 1'b1, twiSdaIn = 1'b1, twiSdaPullLow = 1'b0;
  logic [31:0] twiRamAddr = '0;
  logic [7:0] display_id_ram_read_word, displayIdWord;
  logic auxValid, auxSop, auxEop, auxError, pktWr, audio_sample_valid;
  logic oversampleSeen, twiSclLevel, twiSdaLevel, twiSdaOut, twiSdaOe;
  logic [71:0] auxData, pktData;
  logic [6:0] pktAddr;
  logic [5:0] gcpStatus;
  logic [111:0] aviStatus;
  logic [60:0] vsiStatus;
  logic [19:0] audioCts, audioN;
  logic [255:0] audioData;
  logic [4:0] audioFormat;
  logic [31:0] displayIdRamAddr;
  int fails = 0, n_compared = 0;
  snkaux_out i_snkaux_out (.clk_sys, .rst, .inWord, .gcpLoad, .gcpIn, .aviLoad, .aviIn, .vsiLoad, .vsiIn,
    .acrLoad, .ctsIn, .nIn, .audIn, .audFirst3d, .audTypeIn, .audDataIn, .oversample_indicator, .twiSclIn,
    .twiSdaIn, .twiSdaPullLow, .twiRamAddr, .display_id_ram_read_word, .auxValid, .auxData, .auxSop, .auxEop,
    .auxError, .pktWr, .pktAddr, .pktData, .gcpStatus, .aviStatus, .vsiStatus, .audioCts, .audioN,
    .audio_sample_valid, .audioData, .audioFormat, .oversampleSeen, .twiSclLevel, .twiSdaLevel, .twiSdaOut,
    .twiSdaOe, .displayIdRamAddr, .displayIdWord);
  snkaux_user_model i_snkaux_user_model (.clk_sys, .pktWr, .pktAddr, .pktData, .displayIdRamAddr,
    .display_id_ram_read_word);
  // ----------------------------------------------------------------
  // clock, compare and close
  // ----------------------------------------------------------------
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [255:0] seen, input logic [255:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  function automatic logic [71:0] word(input int k);
    return {8'(k), 64'hF0E1_D2C3_B4A5_9687};
  endfunction
  // back-to-back words, crc flag on one word, then an idle cycle
  // words carry the packet length too, so a missed buffer write shows up
  task automatic send_pkt(input int n, input int bad);
    for (int i = 0; i <= n; i++) begin
      @(posedge clk_sys);
      inWord <= (i < n) ? snkaux_pkg::snkaux_word_s'{1'b1, i == 0, i == n - 1, i == bad, word(n * 16 + i)} : '0;
      if (i > 0) begin
        #1;
        chk("auxValid", auxValid, 1'b1);
        chk("auxData", auxData, word(n * 16 + i - 1));
        chk("auxSop", auxSop, i == 1);
        chk("auxEop", auxEop, i == n);
        chk("auxError", auxError, i - 1 == bad);
        chk("pktWr", pktWr, 1'b1);
        chk("pktAddr", pktAddr, 7'(i - 1));
        chk("pktData", pktData, word(n * 16 + i - 1));
      end
    end
    @(posedge clk_sys);
    #1;
    chk("idle markers", {auxValid, auxSop, auxEop, auxError, pktWr}, 5'h00);
    chk("buffer word", i_snkaux_user_model.mem[n - 1], word(n * 16 + n - 1));
  endtask
  task automatic status_load();
    @(posedge clk_sys);
    {gcpLoad, aviLoad, vsiLoad, acrLoad} <= 4'hF;
    gcpIn <= 6'h2D;
    aviIn <= {11'h7FF, 112'h1234_5678_9ABC_DEF0_1357_9BDF_0246};
    vsiIn <= 61'h1ACE_0F0F_5A5A_C3C3;
    ctsIn <= 20'hABCDE;
    nIn <= 20'h01800;
    @(posedge clk_sys);
    {gcpLoad, aviLoad, vsiLoad, acrLoad} <= 4'h0;
    {gcpIn, aviIn, vsiIn, ctsIn, nIn} <= '0;
    repeat (2) begin
      #1;
      chk("gcpStatus", gcpStatus, 6'h2D);
      chk("aviStatus", aviStatus, 112'h1234_5678_9ABC_DEF0_1357_9BDF_0246);
      chk("vsiStatus", vsiStatus, 61'h1ACE_0F0F_5A5A_C3C3);
      chk("audioCts", audioCts, 20'hABCDE);
      chk("audioN", audioN, 20'h01800);
      @(posedge clk_sys);
    end
  endtask
  // two samples back to back, then data and format must hold
  task automatic audio_pair();
    @(posedge clk_sys);
    {audIn, audFirst3d, audTypeIn, audDataIn} <= {2'b11, 4'h9, {8{32'hC0DE_0001}}};
    @(posedge clk_sys);
    {audIn, audFirst3d, audTypeIn, audDataIn} <= {2'b10, 4'h3, {8{32'hC0DE_0002}}};
    #1;
    chk("audio valid", audio_sample_valid, 1'b1);
    chk("audioData", audioData, {8{32'hC0DE_0001}});
    chk("audioFormat", audioFormat, 5'h19);
    @(posedge clk_sys);
    {audIn, audFirst3d, audTypeIn, audDataIn} <= '0;
    #1;
    chk("audioFormat", audioFormat, 5'h03);
    @(posedge clk_sys);
    #1;
    chk("audio valid", audio_sample_valid, 1'b0);
    chk("audioData", audioData, {8{32'hC0DE_0002}});
    chk("audioFormat", audioFormat, 5'h03);
  endtask
  task automatic pins();
    @(posedge clk_sys);
    {oversample_indicator, twiSclIn, twiSdaIn, twiSdaPullLow} <= 4'b1001;
    twiRamAddr <= 32'h0000_0123;
    @(posedge clk_sys);
    #1;
    chk("twiSdaOe", {twiSdaOe, twiSdaOut}, 2'b10);
    chk("displayIdRamAddr", displayIdRamAddr, 32'h0000_0123);
    chk("pin levels early", {oversampleSeen, twiSclLevel, twiSdaLevel}, 3'b011);
    @(posedge clk_sys);
    #1;
    chk("pin levels", {oversampleSeen, twiSclLevel, twiSdaLevel}, 3'b100);
    chk("displayIdWord", displayIdWord, 8'h23 ^ 8'h5A);
    // one more edge so the oversample check sees three high samples
    @(posedge clk_sys);
    #1;
    chk("oversampleSeen", oversampleSeen, 1'b1);
  endtask
  // ----------------------------------------------------------------
  // main sequence, with a run limit as the hang guard
  // ----------------------------------------------------------------
  initial begin
    #100000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk("reset outputs", {auxValid, pktWr, pktAddr, gcpStatus, audio_sample_valid, twiSdaOe}, '0);
    chk("reset levels", {twiSclLevel, twiSdaLevel}, 2'b11);
    send_pkt(3, 2);
    send_pkt(2, 0);
    status_load();
    audio_pair();
    pins();
    stop_test();
  end
endmodule
`default_nettype wire
